// *** logic/acqtrg_core.sv ***
/*
  Stop trigger, hold gate and scan clock timing with APB registers.
  Assumes inputs synchronous to pclk are still run through two flops,
  and the sample store lives outside: this block gives its write index.
*/
// Function
// - Post count equals buffer size minus pretrigger
// - Watch stop trigger after pretrigger samples taken
// - Ignore stop trigger before pretrigger reached
// - Full buffer wraps, overwriting oldest sample
// - Store exactly post count, then end
// - Stop source selectable, edge selectable
// - Analog stop source uses first rising edge
// - Stop pin outputs high pulse copy
// - Stop pin input after reset
// - Hold gate level sensitive, polarity, never output
// - Analog hold halts internal scan clock
// - Each scan clock samples every channel once
// - Scan clock internal/external, edge selectable
// - Default scan clock divides timebase; else routed
// - Pulse mode: one pin pulse per scan
// - Level mode: high from begin to last conversion
// - Scan pin input after reset
// - Divider started by begin, stopped at end
// - Begin to first scan delay, default two ticks
// - Timebase fast/slow internal or io line, no output
// - Timebase active edge selectable
// - Ignore clocks before begin trigger
// - Ignore scan clocks until conversions done
module acqtrg_core #(
  parameter int ADDR_W = 16
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [acqtrg_pkg::IO_LINES-1:0]   programmable_io_line,
  input  wire logic [acqtrg_pkg::SYNC_LINES-1:0] sync_bus_line,
  input  wire logic                              analog_compare,
  input  wire logic                              fast_internal_timebase,
  input  wire logic                              slow_internal_timebase,
  input  wire logic                              acq_begin_trigger,
  input  wire logic                              conversion_clock,
  input  wire logic                              stop_trigger_pin_in,
  output logic                                   stop_trigger_pin_out,
  output logic                                   stop_trigger_pin_oe,
  input  wire logic                              scan_clock_pin_in,
  output logic                                   scan_clock_pin_out,
  output logic                                   scan_clock_pin_oe,
  output logic                                   scan_clock,
  output logic                                   sample_write,
  output logic      [ADDR_W-1:0]                 sample_addr,
  output logic                                   acq_running,
  output logic                                   acq_done
);
  import acqtrg_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_DELAY, S_PRE, S_WAIT, S_POST} acqtrg_state_t;

  typedef struct packed {
    logic [31:0]         ctrl;
    logic [15:0]         src;
    logic [ADDR_W-1:0]   bufsz;
    logic [ADDR_W-1:0]   pre;
    logic [15:0]         div;
    logic [15:0]         delay;
    logic [7:0]          nconv;
    logic [31:0]         rdata;
    logic                rdy;
    logic                err;
    logic [1:0]          io_s1;
    logic [1:0]          io_s2;
    logic [1:0]          io_s3;
    logic [3:0]          s1;
    logic [3:0]          s2;
    logic [3:0]          s3;
    acqtrg_state_t       st;
    logic [15:0]         cnt;
    logic [ADDR_W-1:0]   nsamp;
    logic [ADDR_W-1:0]   post;
    logic [ADDR_W-1:0]   wptr;
    logic                full;
    logic [7:0]          conv;
    logic                busy;
    logic                done;
    logic                stop_out;
    logic                scan_out;
    logic                scan;
    logic                wr;
  } acqtrg_regs_t;

  acqtrg_regs_t q, d;

  function automatic logic pick(input logic [3:0] sel, input logic [7:0] io,
                                input logic [6:0] sb, input logic an);
    if (sel == SEL_ANALOG) begin
      return an;
    end else if (sel >= SEL_SYNC0) begin
      return sb[3'(sel - SEL_SYNC0)];
    end else begin
      return io[sel[2:0]];
    end
  endfunction

  function automatic logic edge_of(input logic now, input logic prev, input logic fall);
    return fall ? (prev & ~now) : (now & ~prev);
  endfunction

  logic       raw_stop, raw_hold, raw_scan, raw_base;
  logic       stop_lvl, hold_lvl, scan_lvl, base_lvl;
  logic       stop_ev, base_tick, ext_scan, held, scan_take, conv_ev, begin_ev;
  logic [7:0] io_all;

  always_comb begin
    io_all   = programmable_io_line;
    io_all[1] = stop_trigger_pin_oe ? 1'b0 : stop_trigger_pin_in;
    io_all[7] = scan_clock_pin_oe ? 1'b0 : scan_clock_pin_in;
    raw_stop = pick(q.src[SRC_STOP_LSB +: SRC_W], io_all, sync_bus_line, analog_compare);
    raw_hold = pick(q.src[SRC_HOLD_LSB +: SRC_W], io_all, sync_bus_line, analog_compare);
    raw_scan = pick(q.src[SRC_SCAN_LSB +: SRC_W], io_all, sync_bus_line, analog_compare);
    raw_base = q.ctrl[CTRL_BASE_EXT] ? pick(q.src[SRC_BASE_LSB +: SRC_W], io_all, sync_bus_line, 1'b0)
             : (q.ctrl[CTRL_BASE_SLOW] ? slow_internal_timebase : fast_internal_timebase);
    // First stage only feeds the second; detection looks at stages 2 and 3
    stop_lvl = q.s2[0];
    hold_lvl = q.s2[1];
    scan_lvl = q.s2[2];
    base_lvl = q.s2[3];
    // Analog stop source always takes the rising edge
    stop_ev  = edge_of(stop_lvl, q.s3[0],
                       (q.src[SRC_STOP_LSB +: SRC_W] == SEL_ANALOG) ? 1'b0 : q.ctrl[CTRL_STOP_FALL]);
    base_tick = edge_of(base_lvl, q.s3[3], q.ctrl[CTRL_BASE_FALL]);
    ext_scan  = edge_of(scan_lvl, q.s3[2], q.ctrl[CTRL_SCAN_FALL]);
    held      = hold_lvl ^ q.ctrl[CTRL_HOLD_LOW];
    // Rising edge from stages 2 and 3; stage 1 may still be settling
    begin_ev  = q.io_s2[0] & ~q.io_s3[0];
    conv_ev   = q.io_s2[1] & ~q.io_s3[1];
  end

  always_comb begin
    d = q;
    d.rdy     = 1'b0;
    d.err     = 1'b0;
    d.wr      = 1'b0;
    d.scan    = 1'b0;
    d.stop_out = 1'b0;
    d.ctrl[CTRL_GO]   = 1'b0;
    d.ctrl[CTRL_STOP] = 1'b0;
    scan_take = 1'b0;
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    d.s1 = {raw_base, raw_scan, raw_hold, raw_stop};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.io_s1 = {conversion_clock, acq_begin_trigger};
    d.io_s2 = q.io_s1;
    d.io_s3 = q.io_s2;
    // ---------------------------------------------------------------
    // APB slave, one wait state
    // ---------------------------------------------------------------
    if (psel && penable && !q.rdy) begin
      d.rdy = 1'b1;
      if (pwrite) begin
        if (paddr == OFS_CTRL) begin
          d.ctrl = pwdata;
        end else if (paddr == OFS_SRC) begin
          d.src = pwdata[15:0];
        end else if (paddr == OFS_BUFSZ) begin
          d.bufsz = pwdata[ADDR_W-1:0];
        end else if (paddr == OFS_PRE) begin
          d.pre = pwdata[ADDR_W-1:0];
        end else if (paddr == OFS_DIV) begin
          d.div = pwdata[15:0];
        end else if (paddr == OFS_DELAY) begin
          d.delay = pwdata[15:0];
        end else if (paddr == OFS_NCONV) begin
          d.nconv = pwdata[7:0];
        end else if (paddr != OFS_STATUS && paddr != OFS_WPTR && paddr != OFS_POST) begin
          d.err = 1'b1;
        end
      end else begin
        d.rdata = 32'h0000_0000;
        if (paddr == OFS_CTRL) begin
          d.rdata = q.ctrl;
        end else if (paddr == OFS_SRC) begin
          d.rdata[15:0] = q.src;
        end else if (paddr == OFS_BUFSZ) begin
          d.rdata[ADDR_W-1:0] = q.bufsz;
        end else if (paddr == OFS_PRE) begin
          d.rdata[ADDR_W-1:0] = q.pre;
        end else if (paddr == OFS_DIV) begin
          d.rdata[15:0] = q.div;
        end else if (paddr == OFS_DELAY) begin
          d.rdata[15:0] = q.delay;
        end else if (paddr == OFS_NCONV) begin
          d.rdata[7:0] = q.nconv;
        end else if (paddr == OFS_STATUS) begin
          d.rdata[5:0] = {q.full, q.done, q.busy, q.st};
        end else if (paddr == OFS_WPTR) begin
          d.rdata[ADDR_W-1:0] = q.wptr;
        end else if (paddr == OFS_POST) begin
          d.rdata[ADDR_W-1:0] = q.post;
        end else begin
          d.err = 1'b1;
        end
      end
    end
    // ---------------------------------------------------------------
    // Conversion counting gates the next scan clock
    // ---------------------------------------------------------------
    if (q.conv != 8'h00 && conv_ev) begin
      d.conv = q.conv - 8'h01;
      if (q.conv == 8'h01) begin
        d.scan_out = 1'b0;
      end
    end
    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    case (q.st)
      S_IDLE: begin
        d.cnt = q.delay;
        if (q.ctrl[CTRL_GO] || begin_ev) begin
          d.st    = S_DELAY;
          d.busy  = 1'b1;
          d.done  = 1'b0;
          d.full  = 1'b0;
          d.wptr  = '0;
          d.nsamp = '0;
          d.conv  = 8'h00;
          d.post  = q.bufsz - q.pre;
          if (q.ctrl[CTRL_LEVEL]) begin
            d.scan_out = 1'b1;
          end
        end
      end
      S_DELAY: begin
        // Delay counts timebase ticks only for the internal source
        if (q.ctrl[CTRL_SCAN_EXT]) begin
          d.st = q.ctrl[CTRL_USE_STOP] ? S_PRE : S_POST;
        end else if (base_tick) begin
          if (q.cnt <= 16'h0001) begin
            d.cnt = 16'h0000;
            d.st  = q.ctrl[CTRL_USE_STOP] ? S_PRE : S_POST;
          end else begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
      end
      default: begin
        if (!q.ctrl[CTRL_SCAN_EXT]) begin
          if (base_tick && !held) begin
            if (q.cnt == 16'h0000) begin
              d.cnt = (q.div == 16'h0000) ? 16'h0000 : q.div - 16'h0001;
              scan_take = (q.conv == 8'h00);
            end else begin
              d.cnt = q.cnt - 16'h0001;
            end
          end
        end else begin
          scan_take = ext_scan && !held && (q.conv == 8'h00);
        end
        if (q.st == S_WAIT && stop_ev) begin
          d.st    = S_POST;
          d.nsamp = '0;
          d.stop_out = 1'b1;
        end
      end
    endcase
    if (scan_take) begin
      d.scan  = 1'b1;
      d.wr    = 1'b1;
      d.conv  = q.nconv;
      d.wptr  = (q.wptr + 1'b1 == q.bufsz) ? '0 : ADDR_W'(q.wptr + 1'b1);
      d.full  = q.full | (q.wptr + 1'b1 == q.bufsz);
      // Sample taken with the stop edge still counts as pretrigger
      d.nsamp = (q.st == S_WAIT && stop_ev) ? '0 : ADDR_W'(q.nsamp + 1'b1);
      if (q.ctrl[CTRL_LEVEL]) begin
        d.scan_out = 1'b1;
      end
      if (q.st == S_PRE && q.nsamp + 1'b1 >= q.pre) begin
        d.st = S_WAIT;
      end
      if (q.st == S_POST && q.ctrl[CTRL_USE_STOP] && q.nsamp + 1'b1 == q.post) begin
        d.st = S_IDLE;
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      if (q.st == S_POST && !q.ctrl[CTRL_USE_STOP] && q.nsamp + 1'b1 == q.bufsz) begin
        d.st = S_IDLE;
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
    if (q.ctrl[CTRL_STOP]) begin
      d.st   = S_IDLE;
      d.busy = 1'b0;
    end
    if (!q.ctrl[CTRL_LEVEL]) begin
      d.scan_out = d.scan;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.ctrl  <= RST_CTRL;
      q.src   <= RST_SRC[15:0];
      q.div   <= RST_DIV;
      q.delay <= RST_DELAY;
      q.nconv <= RST_NCONV;
      q.st    <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.rdata;
  assign pready  = q.rdy;
  assign pslverr = q.err;
  // Hold gate has no output path by construction
  assign stop_trigger_pin_out = q.stop_out;
  assign stop_trigger_pin_oe  = q.ctrl[CTRL_STOP_OE];
  assign scan_clock_pin_out   = q.scan_out;
  assign scan_clock_pin_oe    = q.ctrl[CTRL_SCAN_OE];
  assign scan_clock           = q.scan;
  assign sample_write         = q.wr;
  assign sample_addr          = q.wptr;
  assign acq_running          = q.busy;
  assign acq_done             = q.done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_stop_hit;
    q.st == S_WAIT && stop_ev;
  endsequence

  AST_PRE_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == S_PRE && stop_ev |=> q.st != S_POST || $past(scan_take)) else $error("stop taken early");
  AST_STOP_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    s_stop_hit |=> stop_trigger_pin_out && q.st == S_POST) else $error("stop not accepted");
  AST_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    stop_trigger_pin_out |=> !stop_trigger_pin_out) else $error("stop pulse too long");
  AST_POST_CALC: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == S_IDLE && $past(q.st) == S_IDLE && begin_ev |=> q.post == $past(q.bufsz - q.pre))
    else $error("post count wrong");
  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    scan_take && q.wptr + 1'b1 == q.bufsz |=> sample_addr == '0) else $error("no wrap");
  AST_IDLE_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    q.st == S_IDLE |=> !scan_clock) else $error("scan while idle");
  AST_CONV_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    q.conv != 8'h00 |-> !scan_take) else $error("scan before conversions");
  AST_SCAN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    scan_take |=> scan_clock && q.conv == $past(q.nconv)) else $error("scan load wrong");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    held |-> !scan_take) else $error("scan while held");
  AST_PULSE_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    !q.ctrl[CTRL_LEVEL] && !$past(q.ctrl[CTRL_LEVEL]) |-> scan_clock_pin_out == scan_clock)
    else $error("pin pulse mismatch");

endmodule : acqtrg_core

// *** pkg/acqtrg_pkg.sv ***
/*
  Shared constants for the acquisition trigger and scan timing block.
  Assumes a single pclk domain and an APB slave with 32-bit data.
*/
package acqtrg_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SRC     = 8'h04;
  localparam logic [7:0] OFS_BUFSZ   = 8'h08;
  localparam logic [7:0] OFS_PRE     = 8'h0c;
  localparam logic [7:0] OFS_DIV     = 8'h10;
  localparam logic [7:0] OFS_DELAY   = 8'h14;
  localparam logic [7:0] OFS_NCONV   = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_WPTR    = 8'h20;
  localparam logic [7:0] OFS_POST    = 8'h24;
  // ---------------------------------------------------------------
  // CTRL fields
  // ---------------------------------------------------------------
  localparam int CTRL_GO       = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_USE_STOP = 2;
  localparam int CTRL_STOP_OE  = 3;
  localparam int CTRL_SCAN_OE  = 4;
  localparam int CTRL_LEVEL    = 5;
  localparam int CTRL_STOP_FALL = 6;
  localparam int CTRL_SCAN_FALL = 7;
  localparam int CTRL_BASE_FALL = 8;
  localparam int CTRL_HOLD_LOW  = 9;
  localparam int CTRL_SCAN_EXT  = 10;
  localparam int CTRL_BASE_EXT  = 11;
  localparam int CTRL_BASE_SLOW = 12;
  // ---------------------------------------------------------------
  // SRC fields: source select, 4 bits each
  // ---------------------------------------------------------------
  localparam int SRC_STOP_LSB = 0;
  localparam int SRC_HOLD_LSB = 4;
  localparam int SRC_SCAN_LSB = 8;
  localparam int SRC_BASE_LSB = 12;
  localparam int SRC_W        = 4;
  // 0..7 io lines, 8..14 sync bus 0..6, 15 internal/analog
  localparam logic [3:0] SEL_SYNC0  = 4'h8;
  localparam logic [3:0] SEL_ANALOG = 4'hf;
  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_SRC   = 32'h0000_0000;
  localparam logic [15:0] RST_DELAY = 16'h0002;
  localparam logic [15:0] RST_DIV   = 16'h0004;
  localparam logic [7:0]  RST_NCONV = 8'h01;
  localparam int          IO_LINES  = 8;
  localparam int          SYNC_LINES = 7;
  localparam int          PULSE_CYCLES = 1;
endpackage : acqtrg_pkg

// *** test/acq_trigger_scan_timing_tb.sv ***
/*
  Self-checking bench: APB set-up, stop trigger runs over three
  sources, hold gate runs. Assumes acqtrg_src_model on the far side.
*/
module acq_trigger_scan_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acqtrg_pkg::*;
  typedef struct {logic [31:0] d; logic e; logic rd;} acqtrg_apb_t;
  typedef struct {logic stop; int post; int bsz;} acqtrg_run_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, io_drv = 0, nconv = 1;
  logic [31:0] pwdata = 0, prdata;
  logic [6:0]  sync_drv = 0;
  logic        an_cmp = 0, begin_trg = 0, slow = 0;
  logic        pready, pslverr, stop_out, stop_oe, scan_out, scan_oe;
  logic        scan_clk, s_wr, fast_tb, slow_tb, conv, done;
  logic [15:0] s_addr;
  wire logic   stop_w = stop_oe ? stop_out : io_drv[1];
  wire logic   scan_w = scan_oe ? scan_out : io_drv[7];
  wire logic [7:0] io_w = {scan_w, io_drv[6:2], stop_w, io_drv[0]};
  acqtrg_apb_t q_apb[$];
  acqtrg_run_t q_run[$];
  int n_fail = 0, samples_checked = 0, seed = 32'h22a3;
  int n_wr, n_post, n_scan, n_stp, n_pin;
  bit seen_stp, done_q, pin_q;

  always #5 pclk = ~pclk;

  acqtrg_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .programmable_io_line(io_w), .sync_bus_line(sync_drv),
    .analog_compare(an_cmp), .fast_internal_timebase(fast_tb),
    .slow_internal_timebase(slow_tb), .acq_begin_trigger(begin_trg),
    .conversion_clock(conv), .stop_trigger_pin_in(stop_w),
    .stop_trigger_pin_out(stop_out), .stop_trigger_pin_oe(stop_oe),
    .scan_clock_pin_in(scan_w), .scan_clock_pin_out(scan_out),
    .scan_clock_pin_oe(scan_oe), .scan_clock(scan_clk), .sample_write(s_wr),
    .sample_addr(s_addr), .acq_running(), .acq_done(done));

  acqtrg_src_model i_src (.pclk(pclk), .presetn(presetn), .scan_clock(scan_clk),
    .slow(slow), .nconv(nconv), .fast_internal_timebase(fast_tb),
    .slow_internal_timebase(slow_tb), .conversion_clock(conv));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Holds the request until pready; the note is judged by the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    q_apb.push_back('{d, e, !wr});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic acq(input logic [31:0] bsz, ctrl, src, input logic st, input int post);
    apb(1, OFS_BUFSZ, bsz, 0);
    apb(1, OFS_SRC, src, 0);
    apb(1, OFS_CTRL, ctrl, 0);
    q_run.push_back('{st, post, int'(bsz)});
    {n_wr, n_post, n_scan, n_stp, n_pin} = '0;
    seen_stp = 0;
    @(posedge pclk);
    begin_trg <= 1'b1;
    repeat (4) @(posedge pclk);
    begin_trg <= 1'b0;
  endtask

  task automatic drive_stop(input int k, input logic v);
    if (k == 0) io_drv[0] <= v;
    else if (k == 1) sync_drv[3] <= v;
    else an_cmp <= v;
  endtask

  // Active edge: rising for io and analog, falling for the sync line
  task automatic stop_pulse(input int k);
    drive_stop(k, k != 1);
    repeat (5) @(posedge pclk);
    drive_stop(k, k == 1);
  endtask

  task automatic wait_wr(input int n);
    repeat (4000) begin
      if (n_wr >= n) break;
      @(posedge pclk);
    end
  endtask

  task automatic wait_done();
    repeat (4000) begin
      if (done === 1'b1) break;
      @(posedge pclk);
    end
    @(posedge pclk);
  endtask
  // ---------------------------------------------------------------
  // Monitor
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    acqtrg_apb_t a;
    acqtrg_run_t r;
    if (pready === 1'b1 && q_apb.size() > 0) begin
      a = q_apb.pop_front();
      if (a.rd) check(prdata, a.d);
      check({31'h0, pslverr}, {31'h0, a.e});
    end
    if (s_wr === 1'b1) n_wr++;
    if (s_wr === 1'b1 && seen_stp) n_post++;
    if (scan_clk === 1'b1) n_scan++;
    if (scan_out === 1'b1 && !pin_q) n_pin++;
    pin_q = (scan_out === 1'b1);
    if (stop_out === 1'b1) n_stp++;
    if (stop_out === 1'b1) seen_stp = 1;
    if (done === 1'b1 && !done_q && q_run.size() > 0) begin
      r = q_run.pop_front();
      check(32'(r.stop ? n_post : n_wr), 32'(r.stop ? r.post : r.bsz));
      check(32'(n_stp), 32'(r.stop));
      check({16'h0, s_addr}, 32'(n_wr % r.bsz));
      check(32'(n_pin), 32'(n_scan));
      check(32'(n_wr), 32'(n_scan));
    end
    done_q = (done === 1'b1);
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    int pre;
    int nc;
    logic [3:0] sel;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, RST_CTRL, 0);
    apb(0, OFS_DIV, {16'h0, RST_DIV}, 0);
    apb(0, OFS_DELAY, {16'h0, RST_DELAY}, 0);
    apb(1, 8'h40, 32'h0000_0000, 1);
    check({30'h0, stop_oe, scan_oe}, 32'h0000_0000);
    $display("test registers finished");
    for (k = 0; k < 3; k++) begin
      pre = 2 + ({$random(seed)} % 3);
      nc = (k == 2) ? 2 : 1;
      nconv <= 8'(nc);
      slow <= 1'($random(seed));
      sel = (k == 0) ? 4'h0 : (k == 1) ? SEL_SYNC0 + 4'h3 : SEL_ANALOG;
      drive_stop(k, k == 1);
      apb(1, OFS_PRE, 32'(pre), 0);
      apb(1, OFS_NCONV, 32'(nc), 0);
      // Hold source io 4 stays low so it never pauses these runs
      acq(32'h0000_0008, k == 1 ? 32'h0000_015c : 32'h0000_001c, {24'h0, 4'h4, sel}, 1, 8 - pre);
      apb(0, OFS_POST, 32'(8 - pre), 0);
      stop_pulse(k);
      wait_wr(6);
      stop_pulse(k);
      wait_done();
      $display("test stop source %0d finished", k);
    end
    for (k = 0; k < 2; k++) begin
      if (k == 0) io_drv[2] <= 1'b1;
      else an_cmp <= 1'b0;
      // Second run uses level pin mode: one rise per scan as well
      acq(32'h0000_0005, k ? 32'h0000_1230 : 32'h0000_0010, k ? 32'h0000_00f0 : 32'h0000_0020, 0, 0);
      repeat (200) @(posedge pclk);
      check(32'(n_scan), 32'h0000_0000);
      if (k == 0) io_drv[2] <= 1'b0;
      else an_cmp <= 1'b1;
      wait_done();
      repeat (100) @(posedge pclk);
      check(32'(n_scan), 32'h0000_0005);
      $display("test hold gate %0d finished", k);
    end
    wrap_up();
  end

  // Five runs of a few hundred cycles each; far below this span
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
endmodule // acq_trigger_scan_timing_tb

// *** test/acqtrg_src_model.sv ***
/*
  Far-side model: fast and slow timebases and the conversion pulses.
  Assumes scan_clock is looped back so conversions follow each scan.
*/
module acqtrg_src_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       scan_clock,
  input  wire logic       slow,
  input  wire logic [7:0] nconv,
  output logic            fast_internal_timebase,
  output logic            slow_internal_timebase,
  output logic            conversion_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // ---------------------------------------------------------------
  // Timebases
  // ---------------------------------------------------------------
  // Free running; fast is under a third of pclk so the sync sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q                  <= 0;
      fast_internal_timebase <= 1'b0;
      slow_internal_timebase <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1;
      if (cnt_q % 3 == 2) fast_internal_timebase <= ~fast_internal_timebase;
      if (cnt_q % 8 == 7) slow_internal_timebase <= ~slow_internal_timebase;
    end
  end
  // ---------------------------------------------------------------
  // Conversions
  // ---------------------------------------------------------------
  // Only after a scan, nconv edges, done well before the next scan
  initial begin
    conversion_clock = 1'b0;
    forever begin
      @(posedge pclk);
      if (scan_clock === 1'b1) begin
        if (slow) repeat (6) @(posedge pclk);
        repeat (nconv) begin
          repeat (2) @(posedge pclk);
          conversion_clock <= 1'b1;
          repeat (2) @(posedge pclk);
          conversion_clock <= 1'b0;
        end
      end
    end
  end
endmodule // acqtrg_src_model
